// >>> include/ifs_pkg.sv
// Constants for the FIFO raw status flag block: register map, field positions,
// reset values and FIFO geometry. Assumes an APB master with 32-bit data.
// Summary of operation
// (R1) Transmit-empty is high while the transmit FIFO is empty, clears itself, resets to one.
// (R2) Transmit-nearly-empty is high while the count is at or below its threshold, resets to one.
// (R3) Transmit-full is high while the transmit FIFO is full, clears itself, resets to zero.
// (R4) Transmit-overrun sets when a write reaches a full transmit FIFO, and resets to zero.
// (R5) Transmit-overrun stays set until software writes a one to its bit of the clear register.
// (R6) After an overrun, software sets the transmit flush bit to discard the corrupted contents.
// (R7) Software watches the full and threshold flags so it never writes a full transmit FIFO.
// (R8) Receive-empty is high while the receive FIFO is empty, clears itself, resets to one.
// (R9) Receive-nearly-full is high while the count is at or above its threshold, resets to zero.
// (R10) A raw flag raises the interrupt only when its mask bit is one; masks reset to zero.
// (R11) The raw status flags are read-only and writes to the raw status register change nothing.
// (R12) The level flags are recomputed every cycle from occupancy and thresholds, never cleared.
package ifs_pkg;

    // FIFO geometry.
    localparam int unsigned FIFO_DEPTH = 64;
    localparam int unsigned CNT_W      = 7;
    localparam logic [6:0]  CNT_FULL   = 7'h40;

    // Register byte offsets.
    localparam logic [11:0] OFS_MASK   = 12'h02C;
    localparam logic [11:0] OFS_RAW    = 12'h030;
    localparam logic [11:0] OFS_MASKED = 12'h034;
    localparam logic [11:0] OFS_CLEAR  = 12'h038;
    localparam logic [11:0] OFS_TXTHR  = 12'h03C;
    localparam logic [11:0] OFS_RXTHR  = 12'h040;
    localparam logic [11:0] OFS_CTRL   = 12'h044;

    // Status field positions.
    localparam int unsigned BIT_TX_EMPTY   = 0;
    localparam int unsigned BIT_TX_NEMPTY  = 1;
    localparam int unsigned BIT_TX_FULL    = 2;
    localparam int unsigned BIT_TX_OVERRUN = 3;
    localparam int unsigned BIT_RX_EMPTY   = 4;
    localparam int unsigned BIT_RX_NFULL   = 5;
    localparam int unsigned NUM_FLAGS      = 6;

    // Reset values, the zero data word and the flush bit position.
    localparam logic [5:0]  RAW_RESET   = 6'h13;
    localparam logic [5:0]  MASK_RESET  = 6'h00;
    localparam logic [6:0]  THR_RESET   = 7'h00;
    localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;
    localparam int unsigned BIT_FLUSH   = 0;

endpackage

// >>> logic/ifs_status.sv
// FIFO raw status flags with mask, clear and one interrupt output, on APB.
// Assumes the FIFO owner supplies occupancy counts and a write strobe on CLK_SYS.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/100ps
module ifs_status
    import ifs_pkg::*;
(
    // Clock and reset.
    input  wire logic                   CLK_SYS,
    input  wire logic                   RST_N,
    // APB slave.
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [11:0]            PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic      [31:0]            PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    // FIFO side, same clock domain.
    input  wire logic [ifs_pkg::CNT_W-1:0] TX_COUNT,
    input  wire logic [ifs_pkg::CNT_W-1:0] RX_COUNT,
    input  wire logic                   TX_WRITE,
    output logic                        TX_FLUSH,
    // Interrupt.
    output logic                        IRQ
);
    import ifs_pkg::*;

    typedef struct packed {
        logic [5:0]  raw;
        logic [5:0]  mask;
        logic [6:0]  tx_thr;
        logic [6:0]  rx_thr;
        logic        flush;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        irq;
    } ifs_state_s;

    ifs_state_s st;
    ifs_state_s next_st;

    // Any mapped offset answers; the rest get an error.
    function automatic logic ifs_mapped(input logic [11:0] a);
        return (a == OFS_MASK) || (a == OFS_RAW) || (a == OFS_MASKED) || (a == OFS_CLEAR) ||
               (a == OFS_TXTHR) || (a == OFS_RXTHR) || (a == OFS_CTRL);
    endfunction

    logic       setup;
    logic       wr;
    logic [5:0] lvl;
    logic       ovr_set;
    logic       ovr_clr;

    // Level flags come straight from occupancy every cycle, so nothing clears them.
    always_comb begin
        setup   = PSEL && !PENABLE;
        wr      = PSEL && PENABLE && PWRITE && st.ready;
        lvl     = '0;
        lvl[BIT_TX_EMPTY]  = (TX_COUNT == '0);                         // R1 R12
        lvl[BIT_TX_NEMPTY] = (TX_COUNT <= st.tx_thr);                  // R2 R12
        lvl[BIT_TX_FULL]   = (TX_COUNT >= CNT_FULL);                   // R3 R12
        lvl[BIT_RX_EMPTY]  = (RX_COUNT == '0);                         // R8 R12
        lvl[BIT_RX_NFULL]  = (RX_COUNT >= st.rx_thr);                  // R9 R12
        ovr_set = TX_WRITE && (TX_COUNT >= CNT_FULL);                  // R4
        ovr_clr = wr && (PADDR == OFS_CLEAR) && PWDATA[BIT_TX_OVERRUN]; // R5
    end

    // Next state: flags, bus registers and the zero-wait-state APB answer.
    always_comb begin
        next_st       = st;
        next_st.raw   = lvl;
        // Set beats clear so an overrun in the clearing cycle is not lost.
        next_st.raw[BIT_TX_OVERRUN] = ovr_set ||
                                      (st.raw[BIT_TX_OVERRUN] && !ovr_clr); // R4 R5
        next_st.ready  = setup;
        next_st.slverr = setup && !ifs_mapped(PADDR);
        next_st.rdata  = DATA_ZERO;
        next_st.flush  = 1'b0;
        if (setup && !PWRITE) begin
            unique case (PADDR)
                OFS_MASK:   next_st.rdata = {26'h0, st.mask};
                OFS_RAW:    next_st.rdata = {26'h0, st.raw};
                OFS_MASKED: next_st.rdata = {26'h0, st.raw & st.mask};
                OFS_TXTHR:  next_st.rdata = {25'h0, st.tx_thr};
                OFS_RXTHR:  next_st.rdata = {25'h0, st.rx_thr};
                default:    next_st.rdata = DATA_ZERO;
            endcase
        end
        // Writes to the raw and masked views fall through untouched.
        if (wr) begin                                                  // R11
            if (PADDR == OFS_MASK) begin
                next_st.mask = PWDATA[5:0];
            end
            if (PADDR == OFS_TXTHR) begin
                next_st.tx_thr = PWDATA[6:0];
            end
            if (PADDR == OFS_RXTHR) begin
                next_st.rx_thr = PWDATA[6:0];
            end
            if (PADDR == OFS_CTRL) begin
                next_st.flush = PWDATA[BIT_FLUSH];                     // R6
            end
        end
        // Interrupt from registered flags so it lags the status by one cycle.
        next_st.irq = |(st.raw & st.mask);                            // R10
        if (!RST_N) begin
            next_st        = '0;
            next_st.raw    = RAW_RESET;                               // R1 R2 R3 R4 R8 R9
            next_st.mask   = MASK_RESET;                              // R10
            next_st.tx_thr = THR_RESET;
            next_st.rx_thr = THR_RESET;
        end
    end

    // Single register for all state.
    always_ff @(posedge CLK_SYS) begin
        st <= next_st;
    end

    assign PRDATA   = st.rdata;
    assign PREADY   = st.ready;
    assign PSLVERR  = st.slverr;
    assign TX_FLUSH = st.flush;
    assign IRQ      = st.irq;

    chk_tx_empty_lvl: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R1
        $past(RST_N) |-> st.raw[BIT_TX_EMPTY] == ($past(TX_COUNT) == 0))
        else $error("tx empty flag wrong");
    chk_tx_nempty_thr: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R2
        $past(RST_N) |-> st.raw[BIT_TX_NEMPTY] == ($past(TX_COUNT) <= $past(st.tx_thr)))
        else $error("tx nearly empty flag wrong");
    chk_tx_full_lvl: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R3
        $past(RST_N) |-> st.raw[BIT_TX_FULL] == ($past(TX_COUNT) == 64))
        else $error("tx full flag wrong");
    chk_ovr_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R4
        TX_WRITE && TX_COUNT == 64 |=> st.raw[BIT_TX_OVERRUN])
        else $error("overrun not set");
    chk_ovr_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R5
        st.raw[BIT_TX_OVERRUN] && !ovr_clr |=> st.raw[BIT_TX_OVERRUN])
        else $error("overrun dropped without clear");
    chk_rx_empty_lvl: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R8
        $past(RST_N) |-> st.raw[BIT_RX_EMPTY] == ($past(RX_COUNT) == 0))
        else $error("rx empty flag wrong");
    chk_rx_nfull_thr: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R9
        $past(RST_N) |-> st.raw[BIT_RX_NFULL] == ($past(RX_COUNT) >= $past(st.rx_thr)))
        else $error("rx nearly full flag wrong");
    chk_irq_masked: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R10
        $past(RST_N) |-> IRQ == |($past(st.raw) & $past(st.mask)))
        else $error("interrupt disagrees with masked status");
    chk_raw_ro: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R11
        wr && PADDR == OFS_RAW && !TX_WRITE
        |=> st.raw[BIT_TX_OVERRUN] == $past(st.raw[BIT_TX_OVERRUN]))
        else $error("raw status changed by write");
    chk_flush_pulse: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R6
        wr && PADDR == OFS_CTRL && PWDATA[BIT_FLUSH] |=> TX_FLUSH)
        else $error("flush pulse missing");
    chk_ready_one: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

endmodule

// >>> sim/testbench.sv
// Self-checking bench for the FIFO raw status flags, driven over APB.
// Assumes the design answers each APB access itself; every wait is bounded.
`timescale 1ns/100ps
module testbench;
    import ifs_pkg::*;
    logic        clk_sys, rst_n, psel, penable, pwrite, tx_write, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, tx_flush, irq;
    logic [6:0]  tx_count, rx_count;
    int          n_fail, checks_done;
    // Occupancy table: transmit count, receive count, expected flags.
    logic [6:0]  tv [6] = '{7'h00, 7'h05, 7'h06, 7'h40, 7'h3F, 7'h00};
    logic [6:0]  rv [6] = '{7'h00, 7'h09, 7'h0A, 7'h00, 7'h00, 7'h40};
    logic [31:0] ev [6] = '{32'h13, 32'h02, 32'h20, 32'h14, 32'h10, 32'h23};

    ifs_status ifs_status_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_COUNT(tx_count),
        .RX_COUNT(rx_count), .TX_WRITE(tx_write), .TX_FLUSH(tx_flush), .IRQ(irq));

    // Free-running system clock at 100 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Compare one value and count it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Print the verdict and end the run.
    task automatic stop_test();
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; data and error are taken at the edge that sees PREADY.
    // An idle edge follows, so no signal is assigned twice in one step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) n_fail++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles.
    initial begin
        #20000;
        n_fail++;
        stop_test();
    end

    // Main sequence.
    initial begin
        {psel, penable, pwrite, tx_write, err} = 5'h00;
        {paddr, pwdata, rd} = '0;
        tx_count    = 7'h00;
        rx_count    = 7'h00;
        n_fail      = 0;
        checks_done = 0;
        rst_n       = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, OFS_MASK, DATA_ZERO);
        check(rd, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, OFS_TXTHR, 32'h0000_0005);
        apb(1'b1, OFS_RXTHR, 32'h0000_000A);
        // Level flags follow occupancy with no clear, at both threshold edges.
        for (int i = 0; i < 6; i++) begin
            tx_count <= tv[i];
            rx_count <= rv[i];
            @(posedge clk_sys);
            apb(1'b0, OFS_RAW, DATA_ZERO);
            check(rd, ev[i]);
        end
        // A write into a full transmit FIFO leaves a sticky overrun.
        tx_count <= 7'h40;
        rx_count <= 7'h00;
        tx_write <= 1'b1;
        @(posedge clk_sys);
        tx_write <= 1'b0;
        tx_count <= 7'h00;
        @(posedge clk_sys);
        apb(1'b1, OFS_RAW, 32'h0000_0000);
        apb(1'b0, OFS_RAW, DATA_ZERO);
        check(rd, 32'h0000_001B);
        apb(1'b1, OFS_MASK, 32'h0000_0008);
        apb(1'b0, OFS_MASK, DATA_ZERO);
        check(rd, 32'h0000_0008);
        check({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, OFS_CLEAR, 32'h0000_0008);
        apb(1'b0, OFS_RAW, DATA_ZERO);
        check(rd, 32'h0000_0013);
        check({31'h0, irq}, 32'h0000_0000);
        apb(1'b0, 12'hFFC, DATA_ZERO);
        check({31'h0, err}, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        check({31'h0, tx_flush}, 32'h0000_0001);
        stop_test();
    end
endmodule
